// file: rtl/tspi_params.svh
`ifndef TSPI_PARAMS_SVH
`define TSPI_PARAMS_SVH

// register byte offsets
`define TSPI_OFF_OUT_EN      8'h00
`define TSPI_OFF_CTRL        8'h04
`define TSPI_OFF_SEL_LO      8'h08
`define TSPI_OFF_SEL_HI      8'h0C
`define TSPI_OFF_STATUS      8'h10

// control register fields
`define TSPI_CTRL_STROBE     0
`define TSPI_CTRL_SCAN_EN    1
`define TSPI_CTRL_SCAN_MODE  2
`define TSPI_CTRL_PRETRIG    3
`define TSPI_CTRL_DIR0_EN    4
`define TSPI_CTRL_DIR1_EN    5
`define TSPI_CTRL_W          6

// status register fields
`define TSPI_STAT_PIN_LSB    0
`define TSPI_STAT_SEL_LSB    16

// reset values
`define TSPI_RST_OUT_EN      10'h000
`define TSPI_RST_CTRL        6'h01
`define TSPI_RST_SEL         4'hF

// source select codes: 0..9 pick a pin, this code picks the internal source
`define TSPI_SEL_INTERNAL    4'hF
`define TSPI_SELS_PER_REG    5

`endif

// file: rtl/tspi_pkg.sv
package tspi_pkg;

   // timing signals, in the order of their dedicated pins
   typedef enum logic [3:0] {
      TS_ACQ_TRIG,
      TS_SECOND_TRIG,
      TS_CONVERT,
      TS_CTR1_SRC,
      TS_CTR1_GATE,
      TS_UPDATE,
      TS_WAVE_TRIG,
      TS_SCAN_START,
      TS_CTR0_SRC,
      TS_CTR0_GATE
   } tspi_tsig_t;

   typedef logic [3:0] tspi_sel_t;

endpackage : tspi_pkg

// file: rtl/tspi_sel_mux.sv
`timescale 1ns/1ns
`include "tspi_params.svh"

module tspi_sel_mux
   import tspi_pkg::*;
#(
   parameter int NUM_PINS = 10
)
(
   // pins and internal source
   input  wire logic [NUM_PINS-1:0] pin_in,
   input  wire logic                internal_src,
   // selection
   input  wire tspi_sel_t           sel,
   // result
   output logic                     chosen
);

   generate
      if (NUM_PINS < 1 || NUM_PINS > 15)
      begin : g_bad_pins
         $error("tspi_sel_mux: NUM_PINS must be 1 to 15");
      end
   endgenerate

   always_comb
   begin
      chosen = 1'b0;
      if (sel == `TSPI_SEL_INTERNAL)
      begin
         chosen = internal_src;
      end
      else if (int'(sel) < NUM_PINS)
      begin
         chosen = pin_in[sel];
      end
   end

endmodule : tspi_sel_mux

// file: rtl/tspi_top.sv
// How it works
// RULE_01: digital lines six/seven steer counter directions
// RULE_02: scan pulse once per conversion when enabled
// RULE_03: soft strobe changes only on software write
// RULE_04: pin zero input also feeds analog trigger
// RULE_05: pin zero drives acquisition start trigger
// RULE_06: pin one drives second trigger, pretrigger only
// RULE_07: pin two drives active-low conversion pulse
// RULE_08: pins three/eight drive selected counter sources
// RULE_09: pins four/nine drive selected counter gates
// RULE_10: dedicated pins carry both counter outputs
// RULE_11: pin five drives active-low update signal
// RULE_12: pin six drives waveform start trigger
// RULE_13: pin seven drives scan start pulse
// RULE_14: dedicated pin carries rate generator output
// RULE_15: each pin is input or dedicated output
// RULE_16: any pin selectable by any timing signal
// RULE_17: per-pin software output driver enable
// RULE_18: enables reset cleared, undriven pin is input
`timescale 1ns/1ns
`include "tspi_params.svh"

module tspi_top
   import tspi_pkg::*;
#(
   parameter int NUM_PINS = 10
)
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // register port
   input  wire logic [7:0]          reg_addr,
   input  wire logic [31:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [31:0]         reg_rdata,
   // programmable timing pins
   input  wire logic [NUM_PINS-1:0] programmable_timing_pin_in,
   output logic      [NUM_PINS-1:0] programmable_timing_pin_out,
   output logic      [NUM_PINS-1:0] programmable_timing_pin_oe,
   // digital lines for counter direction
   input  wire logic                digital_line_six,
   input  wire logic                digital_line_seven,
   // internal timing signals from the engines
   input  wire logic                acquisition_start_trigger,
   input  wire logic                second_phase_trigger,
   input  wire logic                conversion_n,
   input  wire logic                update_n,
   input  wire logic                waveform_start_trigger,
   input  wire logic                scan_start_pulse,
   input  wire logic                conversion_event,
   input  wire logic                counter_zero_output_int,
   input  wire logic                counter_one_output_int,
   input  wire logic                rate_generator_int,
   input  wire logic [NUM_PINS-1:0] internal_source,
   // selected timing signals to the engines
   output logic      [NUM_PINS-1:0] timing_selected,
   output logic                     analog_trigger_source,
   output logic                     counter_zero_count_up,
   output logic                     counter_one_count_up,
   // dedicated outputs
   output logic                     conversion_scan_pulse,
   output logic                     soft_strobe_out_n,
   output logic                     counter_zero_output,
   output logic                     counter_one_output,
   output logic                     rate_generator_output
);

   generate
      if (NUM_PINS != 10)
      begin : g_bad_pins
         $error("tspi_top: the dedicated pin mapping needs NUM_PINS of 10");
      end
   endgenerate

   function automatic tspi_sel_t sel_field(input logic [31:0] v, input int k);
      sel_field = v[k*4 +: 4];
   endfunction : sel_field

   function automatic logic [19:0] sel_pack(input tspi_sel_t s0, input tspi_sel_t s1, input tspi_sel_t s2,
                                            input tspi_sel_t s3, input tspi_sel_t s4);
      sel_pack = {s4, s3, s2, s1, s0};
   endfunction : sel_pack

   // software registers
   logic [NUM_PINS-1:0]      oe_q;
   logic [NUM_PINS-1:0]      oe_d;
   logic [`TSPI_CTRL_W-1:0]  ctrl_q;
   logic [`TSPI_CTRL_W-1:0]  ctrl_d;
   tspi_sel_t                sel_q [NUM_PINS];
   tspi_sel_t                sel_d [NUM_PINS];
   logic [31:0]              rdata_q;
   logic [31:0]              rdata_d;

   logic wr_oe;
   logic wr_ctrl;
   logic wr_lo;
   logic wr_hi;

   assign wr_oe   = reg_wr && (reg_addr == `TSPI_OFF_OUT_EN);
   assign wr_ctrl = reg_wr && (reg_addr == `TSPI_OFF_CTRL);
   assign wr_lo   = reg_wr && (reg_addr == `TSPI_OFF_SEL_LO);
   assign wr_hi   = reg_wr && (reg_addr == `TSPI_OFF_SEL_HI);

   always_comb
   begin
      oe_d   = oe_q;
      ctrl_d = ctrl_q;
      sel_d  = sel_q;
      if (wr_oe)
      begin
         oe_d = reg_wdata[NUM_PINS-1:0]; // RULE_17
      end
      if (wr_ctrl)
      begin
         ctrl_d = reg_wdata[`TSPI_CTRL_W-1:0];
      end
      for (int k = 0; k < `TSPI_SELS_PER_REG; k++)
      begin
         if (wr_lo)
         begin
            sel_d[k] = sel_field(reg_wdata, k); // RULE_16
         end
         if (wr_hi)
         begin
            sel_d[k + `TSPI_SELS_PER_REG] = sel_field(reg_wdata, k); // RULE_16
         end
      end
   end

   // selected timing signals, one mux per signal
   logic [NUM_PINS-1:0] chosen;
   generate
      for (genvar g = 0; g < NUM_PINS; g++)
      begin : g_mux
         tspi_sel_mux #(
            .NUM_PINS     (NUM_PINS)
         ) u_mux (
            .pin_in       (programmable_timing_pin_in),
            .internal_src (internal_source[g]),
            .sel          (sel_q[g]),
            .chosen       (chosen[g])
         );
      end
   endgenerate

   always_comb
   begin
      rdata_d = 32'h00000000;
      if (reg_rd)
      begin
         case (reg_addr)
            `TSPI_OFF_OUT_EN: rdata_d[NUM_PINS-1:0] = oe_q;
            `TSPI_OFF_CTRL:   rdata_d[`TSPI_CTRL_W-1:0] = ctrl_q;
            `TSPI_OFF_SEL_LO: rdata_d[19:0] = sel_pack(sel_q[0], sel_q[1], sel_q[2], sel_q[3], sel_q[4]);
            `TSPI_OFF_SEL_HI: rdata_d[19:0] = sel_pack(sel_q[5], sel_q[6], sel_q[7], sel_q[8], sel_q[9]);
            `TSPI_OFF_STATUS:
            begin
               rdata_d[`TSPI_STAT_PIN_LSB +: NUM_PINS] = programmable_timing_pin_in;
               rdata_d[`TSPI_STAT_SEL_LSB +: NUM_PINS] = timing_selected;
            end
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         oe_q    <= `TSPI_RST_OUT_EN; // RULE_18
         ctrl_q  <= `TSPI_RST_CTRL;
         rdata_q <= 32'h00000000;
         for (int k = 0; k < NUM_PINS; k++)
         begin
            sel_q[k] <= `TSPI_RST_SEL;
         end
      end
      else
      begin
         oe_q    <= oe_d;
         ctrl_q  <= ctrl_d;
         rdata_q <= rdata_d;
         sel_q   <= sel_d;
      end
   end

   // pin and dedicated output path
   logic [NUM_PINS-1:0] pin_out_q;
   logic [NUM_PINS-1:0] pin_out_d;
   logic [NUM_PINS-1:0] tsel_q;
   logic                scan_q;
   logic                scan_d;
   logic                atrig_q;
   logic                up0_q;
   logic                up0_d;
   logic                up1_q;
   logic                up1_d;
   logic                ctr0_q;
   logic                ctr1_q;
   logic                rate_q;

   always_comb
   begin
      pin_out_d = '0;
      pin_out_d[int'(TS_ACQ_TRIG)]    = acquisition_start_trigger; // RULE_05
      pin_out_d[int'(TS_SECOND_TRIG)] = second_phase_trigger && ctrl_q[`TSPI_CTRL_PRETRIG]; // RULE_06
      pin_out_d[int'(TS_CONVERT)]     = conversion_n; // RULE_07
      pin_out_d[int'(TS_CTR1_SRC)]    = chosen[int'(TS_CTR1_SRC)]; // RULE_08
      pin_out_d[int'(TS_CTR1_GATE)]   = chosen[int'(TS_CTR1_GATE)]; // RULE_09
      pin_out_d[int'(TS_UPDATE)]      = update_n; // RULE_11
      pin_out_d[int'(TS_WAVE_TRIG)]   = waveform_start_trigger; // RULE_12
      pin_out_d[int'(TS_SCAN_START)]  = scan_start_pulse; // RULE_13
      pin_out_d[int'(TS_CTR0_SRC)]    = chosen[int'(TS_CTR0_SRC)]; // RULE_08
      pin_out_d[int'(TS_CTR0_GATE)]   = chosen[int'(TS_CTR0_GATE)]; // RULE_09
      // one-cycle high pulse per conversion, only in scanning modes
      scan_d = conversion_event && ctrl_q[`TSPI_CTRL_SCAN_EN] && ctrl_q[`TSPI_CTRL_SCAN_MODE]; // RULE_02
      // count up by default when the digital line is not in charge
      up0_d = ctrl_q[`TSPI_CTRL_DIR0_EN] ? digital_line_six : 1'b1; // RULE_01
      up1_d = ctrl_q[`TSPI_CTRL_DIR1_EN] ? digital_line_seven : 1'b1; // RULE_01
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pin_out_q <= '0;
         tsel_q    <= '0;
         scan_q    <= 1'b0;
         atrig_q   <= 1'b0;
         up0_q     <= 1'b1;
         up1_q     <= 1'b1;
         ctr0_q    <= 1'b0;
         ctr1_q    <= 1'b0;
         rate_q    <= 1'b0;
      end
      else
      begin
         pin_out_q <= pin_out_d; // RULE_15
         tsel_q    <= chosen; // RULE_16
         scan_q    <= scan_d;
         atrig_q   <= programmable_timing_pin_in[0]; // RULE_04
         up0_q     <= up0_d;
         up1_q     <= up1_d;
         ctr0_q    <= counter_zero_output_int; // RULE_10
         ctr1_q    <= counter_one_output_int; // RULE_10
         rate_q    <= rate_generator_int; // RULE_14
      end
   end

   assign reg_rdata                   = rdata_q;
   assign programmable_timing_pin_out = pin_out_q;
   assign programmable_timing_pin_oe  = oe_q; // RULE_17
   assign timing_selected             = tsel_q;
   assign analog_trigger_source       = atrig_q;
   assign counter_zero_count_up       = up0_q;
   assign counter_one_count_up        = up1_q;
   assign conversion_scan_pulse       = scan_q;
   assign soft_strobe_out_n           = ctrl_q[`TSPI_CTRL_STROBE]; // RULE_03
   assign counter_zero_output         = ctr0_q;
   assign counter_one_output          = ctr1_q;
   assign rate_generator_output       = rate_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // flops are still in reset at the release edge, so pass-through checks skip that compare
   property p_dir_zero;
      ctrl_q[`TSPI_CTRL_DIR0_EN] && $stable(ctrl_q) |=> counter_zero_count_up == $past(digital_line_six);
   endproperty
   a_dir_zero: assert property (p_dir_zero) else $error("counter zero direction not from line six"); // RULE_01
   property p_scan_pulse;
      conversion_event |=> conversion_scan_pulse == $past(ctrl_q[`TSPI_CTRL_SCAN_EN] && ctrl_q[`TSPI_CTRL_SCAN_MODE]);
   endproperty
   a_scan_pulse: assert property (p_scan_pulse) else $error("scan pulse does not follow conversion"); // RULE_02
   property p_scan_quiet;
      !conversion_event |=> !conversion_scan_pulse;
   endproperty
   a_scan_quiet: assert property (p_scan_quiet) else $error("scan pulse without conversion"); // RULE_02
   property p_strobe;
      !$stable(soft_strobe_out_n) |-> $past(wr_ctrl) && soft_strobe_out_n == $past(reg_wdata[`TSPI_CTRL_STROBE]);
   endproperty
   a_strobe: assert property (p_strobe) else $error("soft strobe moved without a write"); // RULE_03
   property p_atrig;
      !$past(sys_rst) |-> analog_trigger_source == $past(programmable_timing_pin_in[0]);
   endproperty
   a_atrig: assert property (p_atrig) else $error("analog trigger source not pin zero"); // RULE_04
   property p_acq;
      !$past(sys_rst) |-> programmable_timing_pin_out[0] == $past(acquisition_start_trigger);
   endproperty
   a_acq: assert property (p_acq) else $error("pin zero not acquisition trigger"); // RULE_05
   property p_second;
      !ctrl_q[`TSPI_CTRL_PRETRIG] |=> !programmable_timing_pin_out[1];
   endproperty
   a_second: assert property (p_second) else $error("second trigger driven outside pretrigger"); // RULE_06
   property p_convert;
      !$past(sys_rst) |-> programmable_timing_pin_out[2] == $past(conversion_n);
   endproperty
   a_convert: assert property (p_convert) else $error("pin two not conversion pulse"); // RULE_07
   property p_ctr_src;
      programmable_timing_pin_out[3] == timing_selected[3] && programmable_timing_pin_out[8] == timing_selected[8];
   endproperty
   a_ctr_src: assert property (p_ctr_src) else $error("counter source pin differs from selection"); // RULE_08
   property p_ctr_gate;
      programmable_timing_pin_out[4] == timing_selected[4] && programmable_timing_pin_out[9] == timing_selected[9];
   endproperty
   a_ctr_gate: assert property (p_ctr_gate) else $error("counter gate pin differs from selection"); // RULE_09
   property p_ctr_out;
      !$past(sys_rst) |-> counter_one_output == $past(counter_one_output_int)
          && counter_zero_output == $past(counter_zero_output_int);
   endproperty
   a_ctr_out: assert property (p_ctr_out) else $error("counter outputs not passed through"); // RULE_10
   property p_update;
      !$past(sys_rst) |-> programmable_timing_pin_out[5] == $past(update_n);
   endproperty
   a_update: assert property (p_update) else $error("pin five not update signal"); // RULE_11
   property p_wave_scan;
      !$past(sys_rst) |-> programmable_timing_pin_out[6] == $past(waveform_start_trigger)
          && programmable_timing_pin_out[7] == $past(scan_start_pulse);
   endproperty
   a_wave_scan: assert property (p_wave_scan) else $error("pin six or seven wrong"); // RULE_12 RULE_13
   property p_rate;
      !$past(sys_rst) |-> rate_generator_output == $past(rate_generator_int);
   endproperty
   a_rate: assert property (p_rate) else $error("rate generator not passed through"); // RULE_14
   property p_pin_select;
      sel_q[2] == 4'h4 && $stable(sel_q[2]) |=> timing_selected[2] == $past(programmable_timing_pin_in[4]);
   endproperty
   a_pin_select: assert property (p_pin_select) else $error("selected pin not routed to timing signal"); // RULE_16
   property p_oe_write;
      wr_oe |=> programmable_timing_pin_oe == $past(reg_wdata[NUM_PINS-1:0]);
   endproperty
   a_oe_write: assert property (p_oe_write) else $error("output enable did not take write"); // RULE_17
   property p_oe_hold;
      !wr_oe |=> $stable(programmable_timing_pin_oe);
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("output enable changed without write"); // RULE_18

endmodule : tspi_top

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "tspi_params.svh"
module testbench;
   localparam int LIMIT = 20000;
   logic        clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd, r;
   logic        reg_wr, reg_rd;
   logic [9:0]  pin_wire, programmable_timing_pin_out, programmable_timing_pin_oe;
   logic [9:0]  ext_drv, ext_val, internal_source, timing_selected, pins, e, eo, oe_w;
   logic        digital_line_six, digital_line_seven, acquisition_start_trigger, second_phase_trigger;
   logic        conversion_n, update_n, waveform_start_trigger, scan_start_pulse, conversion_event;
   logic        counter_zero_output_int, counter_one_output_int, rate_generator_int;
   logic        analog_trigger_source, counter_zero_count_up, counter_one_count_up, conversion_scan_pulse;
   logic        soft_strobe_out_n, counter_zero_output, counter_one_output, rate_generator_output;
   logic [5:0]  ctrl;
   logic [39:0] sels;
   logic [31:0] seed;
   int          fails, num_checks, cycles;

   tspi_top u_tspi_top (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .programmable_timing_pin_in(pin_wire), .programmable_timing_pin_out, .programmable_timing_pin_oe,
      .digital_line_six, .digital_line_seven, .acquisition_start_trigger, .second_phase_trigger,
      .conversion_n, .update_n, .waveform_start_trigger, .scan_start_pulse, .conversion_event,
      .counter_zero_output_int, .counter_one_output_int, .rate_generator_int, .internal_source,
      .timing_selected, .analog_trigger_source, .counter_zero_count_up, .counter_one_count_up,
      .conversion_scan_pulse, .soft_strobe_out_n, .counter_zero_output, .counter_one_output,
      .rate_generator_output);

   tspi_ext_equipment u_tspi_ext_equipment (.pin_out(programmable_timing_pin_out),
      .pin_oe(programmable_timing_pin_oe), .ext_drv, .ext_val, .pin_wire);

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic exp_ts(input logic [3:0] code, input logic [9:0] p, input logic isrc);
      if (code == 4'hF)
         return isrc;
      else if (code < 4'hA)
         return p[code];
      return 1'b0;
   endfunction : exp_ts

   // undriven lines read high
   function automatic logic [9:0] exp_wire(input logic [9:0] oe, input logic [9:0] out);
      return (oe & out) | (ext_drv & ~oe & ext_val) | ~(oe | ext_drv);
   endfunction : exp_wire

   task summarize;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
         fails++;
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task rdt(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask : rdt

   task rnd_in;
      @(posedge clk);
      r = xs();
      ext_drv <= r[9:0];
      ext_val <= r[19:10];
      r = xs();
      internal_source <= r[9:0];
      {digital_line_six, digital_line_seven, acquisition_start_trigger, second_phase_trigger, conversion_n,
       update_n, waveform_start_trigger, scan_start_pulse, counter_zero_output_int, counter_one_output_int,
       rate_generator_int} <= r[20:10];
   endtask : rnd_in

   task settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fails = fails + 1;
         summarize();
      end
   end

   initial
   begin
      seed = 32'h4DE8A2A7;
      fails = 0;
      num_checks = 0;
      cycles = 0;
      sys_rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, ext_drv, ext_val, internal_source} = '0;
      {digital_line_six, digital_line_seven, acquisition_start_trigger, second_phase_trigger, conversion_n,
       update_n, waveform_start_trigger, scan_start_pulse, conversion_event, counter_zero_output_int,
       counter_one_output_int, rate_generator_int} = '0;
      repeat (20) rnd_in();
      #1;
      chk(programmable_timing_pin_oe, 10'h000, "oe in reset");
      chk(programmable_timing_pin_out, 10'h000, "pin out in reset");
      chk({conversion_scan_pulse, soft_strobe_out_n}, 2'h1, "scan and strobe in reset");
      chk({counter_zero_count_up, counter_one_count_up}, 2'h3, "count up in reset");
      @(posedge clk);
      sys_rst <= 1'b0;
      rdt(`TSPI_OFF_OUT_EN, rd);
      chk(rd, 32'h0, "out enable reset");
      rdt(`TSPI_OFF_SEL_LO, rd);
      chk(rd, 32'hFFFFF, "select low reset");
      rdt(`TSPI_OFF_SEL_HI, rd);
      chk(rd, 32'hFFFFF, "select high reset");
      rdt(8'h14, rd);
      chk(rd, 32'h0, "unmapped read");
      rdt(`TSPI_OFF_CTRL, rd);
      chk(rd, 32'h1, "control reset");
      @(posedge clk);
      #1 chk(reg_rdata, 32'h0, "read data held too long");
      $display("test reset done");
      for (int i = 0; i < 40; i++)
      begin
         r = (i == 0) ? 32'hFFF55555 : xs();
         sels[19:0] = r[19:0];
         wr(`TSPI_OFF_SEL_LO, r);
         r = (i == 0) ? 32'h00055555 : xs();
         sels[39:20] = r[19:0];
         wr(`TSPI_OFF_SEL_HI, r);
         rnd_in();
         settle();
         pins = exp_wire(10'h000, 10'h000);
         for (int k = 0; k < 10; k++)
            e[k] = exp_ts(sels[4*k +: 4], pins, internal_source[k]);
         chk(timing_selected, e, "selected timing");
         chk(analog_trigger_source, pins[0], "analog trigger source");
         rdt(`TSPI_OFF_STATUS, rd);
         chk(rd, {6'h00, e, 6'h00, pins}, "status");
         rdt(`TSPI_OFF_SEL_LO, rd);
         chk(rd, {12'h000, sels[19:0]}, "select low readback");
         rdt(`TSPI_OFF_SEL_HI, rd);
         chk(rd, {12'h000, sels[39:20]}, "select high readback");
      end
      $display("test input routing done");
      wr(`TSPI_OFF_SEL_LO, 32'hFFFFF);
      wr(`TSPI_OFF_SEL_HI, 32'hFFFFF);
      for (int i = 0; i < 30; i++)
      begin
         r = xs();
         ctrl = r[5:0];
         oe_w = (i == 0) ? 10'h3FF : r[15:6];
         wr(`TSPI_OFF_CTRL, {26'h0, ctrl});
         wr(`TSPI_OFF_OUT_EN, {22'h0, oe_w});
         rnd_in();
         settle();
         eo = {internal_source[9:8], scan_start_pulse, waveform_start_trigger, update_n, internal_source[4:3],
               conversion_n, second_phase_trigger & ctrl[3], acquisition_start_trigger};
         chk(programmable_timing_pin_out, eo, "pin outputs");
         chk(timing_selected, internal_source, "counter routing");
         chk(programmable_timing_pin_oe, oe_w, "output enables");
         chk({counter_zero_output, counter_one_output}, {counter_zero_output_int, counter_one_output_int},
             "counter outputs");
         chk(rate_generator_output, rate_generator_int, "rate output");
         chk(counter_zero_count_up, ctrl[4] ? digital_line_six : 1'b1, "counter zero dir");
         chk(counter_one_count_up, ctrl[5] ? digital_line_seven : 1'b1, "counter one dir");
         chk(soft_strobe_out_n, ctrl[0], "soft strobe");
         rdt(`TSPI_OFF_STATUS, rd);
         chk(rd[9:0], exp_wire(oe_w, eo), "connector levels");
         rdt(`TSPI_OFF_CTRL, rd);
         chk(rd, {26'h0, ctrl}, "control readback");
      end
      $display("test output routing done");
      for (int m = 0; m < 4; m++)
      begin
         wr(`TSPI_OFF_CTRL, {29'h0, m[1:0], 1'b1});
         @(posedge clk);
         conversion_event <= 1'b1;
         @(posedge clk);
         conversion_event <= 1'b0;
         #1 chk(conversion_scan_pulse, m == 3, "scan pulse");
         @(posedge clk);
         #1 chk(conversion_scan_pulse, 1'b0, "scan pulse width");
      end
      $display("test scan pulse done");
      wr(`TSPI_OFF_OUT_EN, 32'h3FF);
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      #1 chk(programmable_timing_pin_oe, 10'h000, "oe after second reset");
      @(posedge clk);
      sys_rst <= 1'b0;
      rdt(`TSPI_OFF_OUT_EN, rd);
      chk(rd, 32'h0, "out enable after second reset");
      $display("test second reset done");
      summarize();
   end
endmodule : testbench

// file: tb/tspi_ext_equipment.sv
`timescale 1ns/1ns
module tspi_ext_equipment
(
   // card side of the connector
   input  wire logic [9:0] pin_out,
   input  wire logic [9:0] pin_oe,
   // what the equipment wants to drive
   input  wire logic [9:0] ext_drv,
   input  wire logic [9:0] ext_val,
   // resolved connector lines
   output logic      [9:0] pin_wire
);
   logic [9:0] eq_drv;
   // equipment backs off where the card drives; lines idle high through pull-ups
   assign eq_drv   = ext_drv & ~pin_oe;
   assign pin_wire = (pin_oe & pin_out) | (eq_drv & ext_val) | ~(pin_oe | eq_drv);
endmodule : tspi_ext_equipment
